// file: testbench/rba_proc_model.sv
// Behavioural model of the processor boards on the backplane
module rba_proc_model
   import rba_pkg::*;
#(
   parameter int HOLD = 4
) (
   // Clock
   input wire logic clk,
   // Board enables from the bench
   input wire logic [NPROC-1:0] req_en,
   input wire logic [NPROC-1:0] kick_en,
   // Backplane
   input wire logic [NPROC-1:0] bus_gnt,
   input wire logic [NPROC-1:0] wd_irq,
   output logic [NPROC-1:0] bus_req,
   output logic [NPROC-1:0] wd_kick,
   output logic [NPROC-1:0] fail_shown
);
   timeunit 1ns;
   timeprecision 1ns;
   int tenure [NPROC] = '{default: 0};
   int tick = 0;
   // Quiet backplane at time zero; boards use the bus HOLD cycles, release,
   // then wait for the grant to fall
   initial begin
      bus_req = '0;
      wd_kick = '0;
      fail_shown = '0;
      forever begin
         @(posedge clk);
         #1;
         tick++;
         for (int i = 0; i < NPROC; i++) begin
            if (bus_gnt[i] && bus_req[i]) begin
               tenure[i]++;
               bus_req[i] = (tenure[i] < HOLD);
            end else if (!bus_gnt[i]) begin
               tenure[i] = 0;
               bus_req[i] = req_en[i];
            end
            wd_kick[i] = kick_en[i] & tick[2];
            fail_shown[i] = wd_irq[i];
         end
      end
   end
endmodule // rba_proc_model

// file: testbench/tb_rack_bus_arbiter_watchdog.sv
// Self-checking testbench for the rack bus arbiter and watchdog
module tb_rack_bus_arbiter_watchdog
   import rba_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int LIMIT = 100;
   logic clk, rst, diag_pass, arb_clk_ok, health_led, mem_lslot, mem_wr, mem_rd, arb_chk;
   logic [SLOT_W-1:0] slot_id;
   logic [NPROC-1:0] bus_req, bus_gnt, wd_kick, wd_irq, req_en, kick_en, gnt_prev, served;
   logic [NPROC-1:0] fail_shown;
   logic [LSLOT_AW-1:0] mem_addr;
   logic [DATA_W-1:0] mem_wdata, mem_rdata, last_rd;
   logic [DATA_W-1:0] mem_m [int];
   int miscompares = 0;
   int comparisons = 0;
   int seed = 32'hc576;
   int grants;
   rba_top #(.WD_LIMIT(WD_CNT_W'(LIMIT))) dut (.clk(clk), .rst(rst), .slot_id(slot_id),
      .diag_pass(diag_pass), .arb_clk_ok(arb_clk_ok), .health_led(health_led),
      .bus_req(bus_req), .bus_gnt(bus_gnt), .wd_kick(wd_kick), .wd_irq(wd_irq),
      .mem_lslot(mem_lslot), .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_rd(mem_rd),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
   rba_proc_model #(.HOLD(4)) board (.clk(clk), .req_en(req_en), .kick_en(kick_en),
      .bus_gnt(bus_gnt), .wd_irq(wd_irq), .bus_req(bus_req), .wd_kick(wd_kick),
      .fail_shown(fail_shown));
   // 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic chk(input string what, input logic [DATA_W-1:0] seen,
                      input logic [DATA_W-1:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic do_reset(input logic [SLOT_W-1:0] slot);
      arb_chk = 1'b0;
      served = '0;
      rst = 1'b1;
      slot_id = slot;
      cyc(4);
      chk("reset_outputs", 16'({bus_gnt, wd_irq, health_led}), 16'h0000);
      rst = 1'b0;
      cyc(3);
   endtask
   task automatic mem_op(input logic wr, input logic ls, input logic [LSLOT_AW-1:0] a,
                         input logic [DATA_W-1:0] d);
      mem_lslot = ls;
      mem_addr = a;
      mem_wdata = d;
      mem_wr = wr;
      mem_rd = ~wr;
      cyc(1);
   endtask
   // Round-robin model: lowest unserved requester, new round when all were served
   function automatic logic [NPROC-1:0] pick(input logic [NPROC-1:0] m);
      logic [NPROC-1:0] p;
      if ((m & ~served) == '0) served = '0;
      p = m & ~served;
      p = p & (~p + 4'h1);
      served = served | p;
      return p;
   endfunction
   // Compare every new grant with the model while arb_chk is set
   always @(posedge clk) begin
      #2;
      if (arb_chk && bus_gnt !== gnt_prev && bus_gnt !== '0) begin
         chk("grant_order", bus_gnt, pick(req_en));
         chk("grant_onehot", 16'($onehot(bus_gnt)), 16'h0001);
         grants++;
      end
      gnt_prev = bus_gnt;
   end
   // Hang guard, about sixteen times the expected run
   initial begin
      #(50 * 30000);
      miscompares++;
      print_verdict();
   end
   initial begin
      logic [NPROC-1:0] masks [3];
      logic [LSLOT_AW-1:0] addrs [8];
      {rst, diag_pass, arb_clk_ok, mem_lslot, mem_wr, mem_rd, arb_chk} = '0;
      {slot_id, req_en, kick_en, mem_addr, mem_wdata, gnt_prev} = '0;
      do_reset(4'h0);
      diag_pass = 1'b1;
      arb_clk_ok = 1'b1;
      cyc(6);
      chk("health_on", health_led, 16'h0001);
      arb_clk_ok = 1'b0;
      cyc(6);
      chk("health_no_clk", health_led, 16'h0000);
      arb_clk_ok = 1'b1;
      $display("test health done");
      masks = '{4'hf, 4'($random(seed)) | 4'h1, 4'ha};
      foreach (masks[k]) begin
         do_reset(4'h0);
         grants = 0;
         arb_chk = 1'b1;
         req_en = masks[k];
         cyc(300);
         chk("grants_made", 16'(grants > 8), 16'h0001);
         req_en = '0;
         arb_chk = 1'b0; // Grants from stale synchronised requests are not modelled
         cyc(20);
      end
      $display("test arbitration done");
      do_reset(4'h6);
      req_en = 4'hf;
      kick_en = 4'hf;
      cyc(30);
      kick_en = '0;
      repeat (60) begin
         cyc(5);
         chk("slot6_quiet", {bus_gnt, wd_irq}, '0);
      end
      req_en = '0;
      $display("test other slot done");
      do_reset(4'h0);
      kick_en = 4'hf;
      cyc(3 * LIMIT);
      chk("wd_kicked", wd_irq, 16'h0000);
      kick_en = 4'hb;
      cyc(LIMIT - 15);
      chk("wd_early", wd_irq, 16'h0000);
      cyc(35);
      chk("wd_lapse", wd_irq, 16'h000b);
      chk("fail_shown", fail_shown, 16'h000b);
      kick_en = 4'hf;
      cyc(30);
      chk("wd_sticky", wd_irq, 4'hb);
      slot_id = 4'h2;
      cyc(6);
      chk("wd_off_slot", wd_irq, 16'h0000);
      kick_en = '0;
      $display("test watchdog done");
      do_reset(4'h2);
      foreach (addrs[i]) begin
         addrs[i] = (i == 0) ? 15'h7fff : 15'($random(seed));
         for (int ls = 0; ls < 2; ls++) begin
            mem_m[{ls[0], addrs[i]}] = 16'($random(seed));
            mem_op(1'b1, ls[0], addrs[i], mem_m[{ls[0], addrs[i]}]);
         end
      end
      foreach (addrs[i]) begin
         for (int ls = 0; ls < 2; ls++) begin
            mem_op(1'b0, ls[0], addrs[i], '0);
            chk("mem_read", mem_rdata, mem_m[{ls[0], addrs[i]}]);
         end
      end
      // Write then read the same word on the next cycle
      mem_m[{1'b1, addrs[1]}] = 16'($random(seed));
      mem_op(1'b1, 1'b1, addrs[1], mem_m[{1'b1, addrs[1]}]);
      mem_op(1'b0, 1'b1, addrs[1], '0);
      chk("mem_rewrite", mem_rdata, mem_m[{1'b1, addrs[1]}]);
      last_rd = mem_rdata;
      slot_id = 4'h0;
      cyc(3);
      mem_op(1'b0, 1'b0, addrs[0], '0);
      chk("mem_slot0_ignored", mem_rdata, last_rd);
      slot_id = 4'h3;
      cyc(3);
      mem_op(1'b0, 1'b0, addrs[0], '0);
      chk("mem_odd_ignored", mem_rdata, last_rd);
      mem_rd = 1'b0;
      $display("test storage done");
      print_verdict();
   end
endmodule // tb_rack_bus_arbiter_watchdog

// file: verilog/rba_pkg.sv
// Shared constants and types for the rack bus arbiter and watchdog
package rba_pkg;
   // Processor slots served by the arbiter
   localparam int NPROC = 4;
   localparam int SLOT_W = 4;
   localparam logic [3:0] FIRST_SLOT = 4'h0;
   // Storage geometry: two logical slots of 32K words each
   localparam int LSLOT_AW = 15;
   localparam int MEM_AW = 16;
   localparam int MEM_WORDS = 65536;
   localparam int DATA_W = 16;
   // Clock and watchdog timing
   localparam int CLK_HZ = 20_000_000;
   localparam int WD_TIMEOUT_MS = 100;
   localparam int WD_CYCLES_RAW = (CLK_HZ / 1000) * WD_TIMEOUT_MS;
   localparam int WD_CYCLES = (WD_CYCLES_RAW < 1) ? 1 : WD_CYCLES_RAW;
   localparam int WD_CNT_W = 24;
   // Reset values
   localparam logic [NPROC-1:0] GNT_RST = 4'h0;
   localparam logic [NPROC-1:0] SERVED_RST = 4'h0;
   localparam logic [DATA_W-1:0] RDATA_RST = 16'h0000;
   localparam logic [WD_CNT_W-1:0] WD_CNT_RST = 24'h000000;
   // Arbiter states
   typedef enum logic [1:0] {
      ARB_IDLE = 2'b01,
      ARB_BUSY = 2'b10
   } rba_arb_state_type;
endpackage

// file: verilog/rba_top.sv
// Backplane bus arbiter, shared watchdog and word storage
// Overview of operation
// - Arbitration works only when the module sits in slot zero.
// - Requests come from at most four processors in slots one to four.
// - Every requester gets one grant before anyone gets a second.
// - Simultaneous first-time requesters: lower slot is granted first.
// - Processors restart the watchdog; a lapse interrupts the other processors.
// - Watchdog runs only in slot zero.
// - In other even slots the module is storage spanning two logical slots.
// - Each logical slot decodes words 0-32767; second reaches upper 32K.
// - Health light needs slot zero, passed diagnostics and arbitration clock.
module rba_top
   import rba_pkg::*;
#(
   parameter logic [WD_CNT_W-1:0] WD_LIMIT = WD_CNT_W'(WD_CYCLES)
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Slot position and health pins
   input wire logic [SLOT_W-1:0] slot_id,
   input wire logic diag_pass,
   input wire logic arb_clk_ok,
   output logic health_led,
   // Bus arbitration, bit i is processor slot i+1
   input wire logic [NPROC-1:0] bus_req,
   output logic [NPROC-1:0] bus_gnt,
   // Watchdog
   input wire logic [NPROC-1:0] wd_kick,
   output logic [NPROC-1:0] wd_irq,
   // Storage access, synchronous to clk
   input wire logic mem_lslot,
   input wire logic [LSLOT_AW-1:0] mem_addr,
   input wire logic mem_wr,
   input wire logic mem_rd,
   input wire logic [DATA_W-1:0] mem_wdata,
   output logic [DATA_W-1:0] mem_rdata
);
   logic [SLOT_W-1:0] slot_m, slot_s;
   logic [NPROC-1:0] req_m, req_s, kick_m, kick_s, kick_p;
   logic diag_m, diag_s, clkok_m, clkok_s;
   logic first_slot, storage_mode;
   rba_arb_state_type state_q, state_d;
   logic [NPROC-1:0] gnt_q, gnt_d, served_q, served_d;
   logic [NPROC-1:0] irq_q, irq_d, expired;
   logic health_q, health_d;
   logic [DATA_W-1:0] mem [MEM_WORDS];
   logic [DATA_W-1:0] rdata_q, rdata_d;
   logic [MEM_AW-1:0] word_idx;

   // Two-stage synchronisers for slot, request, kick, diagnostic and clock-status pins
   always_ff @(posedge clk) begin
      if (rst) begin
         slot_m <= 4'h1;
         slot_s <= 4'h1;
         req_m <= 4'h0;
         req_s <= 4'h0;
         kick_m <= 4'h0;
         kick_s <= 4'h0;
         kick_p <= 4'h0;
         diag_m <= 1'b0;
         diag_s <= 1'b0;
         clkok_m <= 1'b0;
         clkok_s <= 1'b0;
      end else begin
         slot_m <= slot_id;
         slot_s <= slot_m;
         req_m <= bus_req;
         req_s <= req_m;
         kick_m <= wd_kick;
         kick_s <= kick_m;
         kick_p <= kick_s;
         diag_m <= diag_pass;
         diag_s <= diag_m;
         clkok_m <= arb_clk_ok;
         clkok_s <= clkok_m;
      end
   end

   // Mode decode from the slot position
   assign first_slot = (slot_s == FIRST_SLOT);
   assign storage_mode = !slot_s[0] && !first_slot;

   // Arbiter: lowest unserved requester wins, served set clears per round
   always_comb begin
      logic [NPROC-1:0] pend;
      logic found;
      pend = 4'h0;
      found = 1'b0;
      state_d = state_q;
      gnt_d = gnt_q;
      served_d = served_q;
      if (!first_slot) begin
         state_d = ARB_IDLE;
         gnt_d = GNT_RST;
         served_d = SERVED_RST;
      end else begin
         unique case (state_q)
            ARB_IDLE: begin
               pend = req_s & ~served_q;
               if (pend == 4'h0) begin
                  pend = req_s; // Everyone waiting was served: new round
                  served_d = SERVED_RST;
               end
               for (int i = 0; i < NPROC; i++) begin
                  if (pend[i] && !found) begin
                     found = 1'b1;
                     gnt_d = GNT_RST;
                     gnt_d[i] = 1'b1;
                     served_d[i] = 1'b1;
                     state_d = ARB_BUSY;
                  end
               end
            end
            ARB_BUSY: begin
               if ((req_s & gnt_q) == 4'h0) begin
                  gnt_d = GNT_RST;
                  state_d = ARB_IDLE;
               end
            end
            default: begin
               state_d = ARB_IDLE;
               gnt_d = GNT_RST;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= ARB_IDLE;
         gnt_q <= GNT_RST;
         served_q <= SERVED_RST;
      end else begin
         state_q <= state_d;
         gnt_q <= gnt_d;
         served_q <= served_d;
      end
   end

   // Watchdog timers, enabled only in the first slot
   rba_watchdog #(
      .WD_LIMIT(WD_LIMIT)
   ) u_wd (
      .clk(clk),
      .rst(rst),
      .en(first_slot),
      .restart(kick_s & ~kick_p),
      .expired(expired)
   );

   // Interrupt every processor except the one that lapsed
   always_comb begin
      irq_d = 4'h0;
      for (int i = 0; i < NPROC; i++) begin
         irq_d[i] = first_slot && ((expired & ~(4'h1 << i)) != 4'h0);
      end
   end

   // Health light and interrupt registers
   always_comb begin
      health_d = first_slot && diag_s && clkok_s;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_q <= 4'h0;
         health_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
         health_q <= health_d;
      end
   end

   // Word storage: logical slot selects the upper 32K
   assign word_idx = {mem_lslot, mem_addr};

   always_comb begin
      rdata_d = rdata_q;
      if (storage_mode && mem_rd) begin
         rdata_d = mem[word_idx];
      end
   end

   always_ff @(posedge clk) begin
      if (storage_mode && mem_wr) begin
         mem[word_idx] <= mem_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_q <= RDATA_RST;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign bus_gnt = gnt_q;
   assign wd_irq = irq_q;
   assign health_led = health_q;
   assign mem_rdata = rdata_q;

   // Checks
   a_single_grant: assert property (@(posedge clk) disable iff (rst)
      $onehot0(gnt_q))
      else $error("more than one grant");
   a_grant_held: assert property (@(posedge clk) disable iff (rst)
      (gnt_q != 4'h0) && ((gnt_q & req_s) != 4'h0) && first_slot |=> gnt_q == $past(gnt_q))
      else $error("grant dropped while still requested");
   a_off_slot_idle: assert property (@(posedge clk) disable iff (rst)
      !first_slot |=> gnt_q == 4'h0 && irq_q == 4'h0)
      else $error("arbiter or watchdog active outside first slot");
   a_lower_first: assert property (@(posedge clk) disable iff (rst)
      first_slot && state_q == ARB_IDLE && req_s[0] && !served_q[0] |=> gnt_q == 4'h1)
      else $error("lowest unserved slot not granted");
   a_fair_round: assert property (@(posedge clk) disable iff (rst)
      first_slot && state_q == ARB_IDLE && (req_s & ~served_q) != 4'h0
      |=> (gnt_q & $past(served_q)) == 4'h0)
      else $error("second grant while another waits");
   a_health_led: assert property (@(posedge clk) disable iff (rst)
      health_led |-> $past(first_slot) && $past(diag_s) && $past(clkok_s))
      else $error("health light without its conditions");
   a_irq_survivor: assert property (@(posedge clk) disable iff (rst)
      first_slot && $onehot(expired) |=> wd_irq == ~$past(expired))
      else $error("wrong processors interrupted");
   a_mem_readback: assert property (@(posedge clk) disable iff (rst)
      storage_mode && mem_wr && !mem_rd ##1 storage_mode && mem_rd && !mem_wr
      && word_idx == $past(word_idx) |=> mem_rdata == $past(mem_wdata, 2))
      else $error("stored word not read back");

   c_grant_two: cover property (@(posedge clk) disable iff (rst)
      gnt_q == 4'h1 ##[1:20] gnt_q == 4'h2);
   c_new_round: cover property (@(posedge clk) disable iff (rst)
      state_q == ARB_IDLE && served_q == 4'hf && req_s != 4'h0);
   c_wd_irq: cover property (@(posedge clk) disable iff (rst) wd_irq != 4'h0);
   c_upper_write: cover property (@(posedge clk) disable iff (rst)
      storage_mode && mem_wr && mem_lslot);
endmodule // rba_top

// file: verilog/rba_watchdog.sv
// Per-processor watchdog timers of the shared watchdog
module rba_watchdog
   import rba_pkg::*;
#(
   parameter logic [WD_CNT_W-1:0] WD_LIMIT = WD_CNT_W'(WD_CYCLES)
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control
   input wire logic en,
   input wire logic [NPROC-1:0] restart,
   // Status
   output logic [NPROC-1:0] expired
);
   logic [NPROC-1:0] armed_q, armed_d, exp_q, exp_d;
   logic [WD_CNT_W-1:0] cnt_q [NPROC];
   logic [WD_CNT_W-1:0] cnt_d [NPROC];

   // One timer per slot, armed by that processor's first restart
   for (genvar i = 0; i < NPROC; i++) begin : g_tmr
      always_comb begin
         armed_d[i] = armed_q[i];
         exp_d[i] = exp_q[i];
         cnt_d[i] = cnt_q[i];
         if (!en) begin
            armed_d[i] = 1'b0;
            exp_d[i] = 1'b0;
            cnt_d[i] = WD_CNT_RST;
         end else if (restart[i]) begin
            armed_d[i] = 1'b1;
            cnt_d[i] = WD_CNT_RST;
         end else if (armed_q[i] && !exp_q[i]) begin
            if (cnt_q[i] == WD_LIMIT - 1'b1) begin
               exp_d[i] = 1'b1;
            end else begin
               cnt_d[i] = cnt_q[i] + 1'b1;
            end
         end
      end

      always_ff @(posedge clk) begin
         if (rst) begin
            armed_q[i] <= 1'b0;
            exp_q[i] <= 1'b0;
            cnt_q[i] <= WD_CNT_RST;
         end else begin
            armed_q[i] <= armed_d[i];
            exp_q[i] <= exp_d[i];
            cnt_q[i] <= cnt_d[i];
         end
      end

      // Expiry only after the full count with no restart
      a_expiry_count: assert property (@(posedge clk) disable iff (rst)
         $rose(exp_q[i]) |-> $past(en) && $past(cnt_q[i]) == WD_LIMIT - 1'b1)
         else $error("watchdog expired at wrong count");
   end

   assign expired = exp_q;
endmodule // rba_watchdog
